// ===== inc/opaddr_defs.svh
// Purpose: numeric constants for operand fetch and address generation
// Assumes: included by bare name, guarded against double inclusion
// Notes:   lengths are counted in bytes including the opcode
`ifndef OPADDR_DEFS_SVH
`define OPADDR_DEFS_SVH
`define OA_INSTR_COUNT 62
`define OA_MODE_COUNT  8
`define OA_LEN_ONE     2'h1
`define OA_LEN_TWO     2'h2
`define OA_LEN_THREE   2'h3
`define OA_PAGE_ZERO   8'h00
`define OA_IX8_MAX     16'h01fe
`define OA_RST_WORD    16'h0000
`define OA_RST_BYTE    8'h00
`define OA_ONE_WORD    16'h0001
`define OA_TWO_WORD    16'h0002
`endif

// ===== inc/opaddr_pkg.sv
// Purpose: types shared by the operand addressing block
// Assumes: mode and group codes come from an outside opcode table
// Notes:   state codes are one-hot
package opaddr_pkg;
  typedef enum logic [2:0] {
    MODE_INH = 3'h0,
    MODE_IMM = 3'h1,
    MODE_DIR = 3'h2,
    MODE_EXT = 3'h3,
    MODE_IX0 = 3'h4,
    MODE_IX1 = 3'h5,
    MODE_IX2 = 3'h6,
    MODE_REL = 3'h7
  } mode_t;
  typedef enum logic [2:0] {
    GRP_REGMEM = 3'h0,
    GRP_RMW    = 3'h1,
    GRP_JUMP   = 3'h2,
    GRP_BIT    = 3'h3,
    GRP_CTRL   = 3'h4
  } group_t;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_OP1  = 4'h2,
    ST_OP2  = 4'h4,
    ST_CALC = 4'h8
  } state_t;
endpackage : opaddr_pkg

// ===== inc/ea_if.sv
// Purpose: carries one address sum between the sequencer and the adder
// Assumes: purely combinational path
// Notes:   sum is always 16 bits wide
`timescale 1ns/1ps
interface ea_if;
  logic [15:0] base;
  logic [15:0] offset;
  logic [15:0] sum;
  modport req  (output base, output offset, input sum);
  modport calc (input base, input offset, output sum);
endinterface : ea_if

// ===== rtl/ea_adder.sv
// Purpose: unsigned 16-bit effective address adder
// Assumes: operands already zero or sign extended by the caller
// Notes:   carry out of bit 15 is dropped so addresses wrap
`timescale 1ns/1ps
module ea_adder (
  ea_if.calc ea  // base, offset in; sum out
);
  logic [16:0] full_w;
  // wide sum, then cut to the address width
  assign full_w = {1'b0, ea.base} + {1'b0, ea.offset};
  assign ea.sum = full_w[15:0]; // RL14
endmodule : ea_adder

// ===== rtl/cpu_operand_addressing.sv
// Purpose: operand byte fetch and effective address forming for an 8-bit cpu
// Assumes: memory returns read data the cycle after the read strobe
// Notes:   mode, group and branch outcome are supplied by the opcode table
`timescale 1ns/1ps
`include "opaddr_defs.svh"
// Functional notes
// [RL1] instruction set: 62 instructions, eight modes
// [RL2] multiply: high byte to index, low accumulator
// [RL3] inherent: one byte, no operand address
// [RL4] immediate: two bytes, second is literal
// [RL5] direct: second byte low, high forced zero
// [RL6] extended: three bytes, high then low
// [RL7] indexed no offset: one byte, page zero
// [RL8] indexed 8-bit: index plus byte, two bytes
// [RL9] indexed 16-bit: index plus high-low offset
// [RL10] taken branch: pc plus signed offset
// [RL11] untaken branch: continue with next instruction
// [RL12] offset signed byte, from next instruction
// [RL13] classify into five instruction groups
// [RL14] address sums are 16-bit and wrap
module cpu_operand_addressing (
  input  wire logic                core_clk_in,     // system clock
  input  wire logic                rst_in,          // async reset, high
  input  wire logic                start_in,        // opcode present, level
  input  wire opaddr_pkg::mode_t   mode_in,         // addressing mode
  input  wire opaddr_pkg::group_t  group_in,        // instruction group
  input  wire logic                mul_in,          // opcode is multiply
  input  wire logic                take_in,         // branch condition true
  input  wire logic [15:0]         pc_in,           // opcode address
  input  wire logic [7:0]          acc_in,          // accumulator value
  input  wire logic [7:0]          idx_in,          // index register value
  input  wire logic [7:0]          mem_rdata_in,    // memory read data
  output logic                     busy_out,        // sequence in progress
  output logic                     mem_rd_out,      // memory read strobe
  output logic [15:0]              mem_addr_out,    // memory read address
  output logic                     done_out,        // results valid pulse
  output logic                     ea_valid_out,    // operand address formed
  output logic [15:0]              ea_out,          // effective address
  output logic                     literal_valid_out, // immediate value present
  output logic [7:0]               literal_out,     // immediate value
  output logic [15:0]              next_pc_out,     // next instruction address
  output logic [1:0]               len_out,         // instruction length
  output opaddr_pkg::group_t       group_out,       // instruction group
  output logic                     regs_wr_out,     // acc and idx update pulse
  output logic [7:0]               acc_out,         // new accumulator
  output logic [7:0]               idx_out          // new index register
);
  import opaddr_pkg::*;

  state_t      state_r;
  state_t      state_nxt;
  mode_t       mode_r;
  group_t      group_r;
  logic        mul_r;
  logic        take_r;
  logic [15:0] pc_r;
  logic [7:0]  acc_q_r;
  logic [7:0]  idx_q_r;
  logic [7:0]  b1_r;
  logic [7:0]  b2_r;
  logic        dvld_r;
  logic [15:0] rd_addr_nxt;
  logic        rd_nxt;

  ea_if ea ();

  // length of an instruction from its mode
  function automatic logic [1:0] len_of(input mode_t m);
    logic [1:0] l;
    l = `OA_LEN_TWO; // RL4 RL5 RL8
    if (m == MODE_INH || m == MODE_IX0) l = `OA_LEN_ONE; // RL3 RL7
    if (m == MODE_EXT || m == MODE_IX2) l = `OA_LEN_THREE; // RL6 RL9
    return l;
  endfunction : len_of

  // decode of the request and of the held mode
  wire         take_w    = start_in && (state_r == ST_IDLE);
  wire [1:0]   len_in_w  = len_of(mode_in); // RL1
  wire [1:0]   len_r_w   = len_of(mode_r);
  wire [15:0]  seq_pc_w  = 16'(pc_r + {14'h0000, len_r_w}); // RL11 RL12
  wire         ix_w      = (mode_r == MODE_IX0) || (mode_r == MODE_IX1) || (mode_r == MODE_IX2);
  wire         addr_md_w = ix_w || (mode_r == MODE_DIR) || (mode_r == MODE_EXT); // RL3 RL4
  wire [15:0]  mul_w     = {`OA_PAGE_ZERO, acc_q_r} * {`OA_PAGE_ZERO, idx_q_r}; // both widened, full product
  wire [15:0]  b1_zx_w   = {`OA_PAGE_ZERO, b1_r};
  wire [15:0]  b12_w     = {b1_r, b2_r};
  wire [15:0]  b1_sx_w   = {{8{b1_r[7]}}, b1_r};

  // adder operand selection
  assign ea.base   = (mode_r == MODE_REL) ? seq_pc_w :            // RL12
                     ix_w ? {`OA_PAGE_ZERO, idx_q_r} : `OA_RST_WORD; // RL7
  assign ea.offset = (mode_r == MODE_DIR) ? b1_zx_w :              // RL5
                     (mode_r == MODE_EXT) ? b12_w :                // RL6
                     (mode_r == MODE_IX1) ? b1_zx_w :              // RL8
                     (mode_r == MODE_IX2) ? b12_w :                // RL9
                     (mode_r == MODE_REL) ? b1_sx_w : `OA_RST_WORD; // RL10

  ea_adder u_add (
    .ea (ea.calc)
  );

  // sequencing and operand reads
  always_comb begin
    state_nxt   = state_r;
    rd_nxt      = 1'b0;
    rd_addr_nxt = mem_addr_out;
    case (state_r)
      ST_IDLE: begin
        if (take_w) begin
          if (len_in_w == `OA_LEN_ONE) begin
            state_nxt = ST_CALC; // RL3
          end else begin
            state_nxt   = ST_OP1;
            rd_nxt      = 1'b1;
            rd_addr_nxt = 16'(pc_in + `OA_ONE_WORD);
          end
        end
      end
      ST_OP1: begin
        if (dvld_r) begin
          if (len_r_w == `OA_LEN_THREE) begin
            state_nxt   = ST_OP2; // RL6 RL9
            rd_nxt      = 1'b1;
            rd_addr_nxt = 16'(pc_r + `OA_TWO_WORD);
          end else begin
            state_nxt = ST_CALC;
          end
        end
      end
      ST_OP2: begin
        if (dvld_r) state_nxt = ST_CALC;
      end
      ST_CALC: state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  // state, strobe and memory address
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_r      <= ST_IDLE;
      mem_rd_out   <= 1'b0;
      mem_addr_out <= `OA_RST_WORD;
      dvld_r       <= 1'b0;
      busy_out     <= 1'b0;
    end else begin
      state_r      <= state_nxt;
      mem_rd_out   <= rd_nxt;
      mem_addr_out <= rd_addr_nxt;
      dvld_r       <= mem_rd_out;
      busy_out     <= (state_nxt != ST_IDLE);
    end
  end

  // request capture
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      mode_r  <= MODE_INH;
      group_r <= GRP_REGMEM;
      mul_r   <= 1'b0;
      take_r  <= 1'b0;
      pc_r    <= `OA_RST_WORD;
      acc_q_r <= `OA_RST_BYTE;
      idx_q_r <= `OA_RST_BYTE;
    end else if (take_w) begin
      mode_r  <= mode_in;
      group_r <= group_in; // RL13
      mul_r   <= mul_in && (mode_in == MODE_INH);
      take_r  <= take_in && (mode_in == MODE_REL); // RL10
      pc_r    <= pc_in;
      acc_q_r <= acc_in;
      idx_q_r <= idx_in;
    end
  end

  // operand bytes, first then second
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      b1_r <= `OA_RST_BYTE;
      b2_r <= `OA_RST_BYTE;
    end else begin
      if (state_r == ST_OP1 && dvld_r) b1_r <= mem_rdata_in;
      if (state_r == ST_OP2 && dvld_r) b2_r <= mem_rdata_in;
    end
  end

  // result registers, loaded in the final step
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      done_out          <= 1'b0;
      ea_valid_out      <= 1'b0;
      ea_out            <= `OA_RST_WORD;
      literal_valid_out <= 1'b0;
      literal_out       <= `OA_RST_BYTE;
      next_pc_out       <= `OA_RST_WORD;
      len_out           <= `OA_LEN_ONE;
      group_out         <= GRP_REGMEM;
      regs_wr_out       <= 1'b0;
      acc_out           <= `OA_RST_BYTE;
      idx_out           <= `OA_RST_BYTE;
    end else begin
      done_out          <= (state_r == ST_CALC);
      ea_valid_out      <= (state_r == ST_CALC) && addr_md_w;
      literal_valid_out <= (state_r == ST_CALC) && (mode_r == MODE_IMM); // RL4
      regs_wr_out       <= (state_r == ST_CALC) && mul_r;
      if (state_r == ST_CALC) begin
        ea_out      <= addr_md_w ? ea.sum : `OA_RST_WORD;
        literal_out <= b1_r; // RL4
        next_pc_out <= take_r ? ea.sum : seq_pc_w; // RL10 RL11
        len_out     <= len_r_w;
        group_out   <= group_r; // RL13
        if (mul_r) begin
          idx_out <= mul_w[15:8]; // RL2
          acc_out <= mul_w[7:0]; // RL2
        end
      end
    end
  end

  // checks
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  wire [15:0] chk_ix0_w = {`OA_PAGE_ZERO, idx_q_r};
  wire [15:0] chk_ix1_w = {`OA_PAGE_ZERO, idx_q_r} + b1_zx_w;
  wire [15:0] chk_ix2_w = 16'({`OA_PAGE_ZERO, idx_q_r} + b12_w);
  wire [15:0] chk_rel_w = 16'(pc_r + `OA_TWO_WORD + b1_sx_w);
  wire [15:0] chk_seq_w = 16'(pc_r + `OA_TWO_WORD);

  inh_no_read_a: assert property (take_w && mode_in == MODE_INH |=> !mem_rd_out [*3]) // RL3
    else $error("inherent instruction issued an operand read");
  imm_fetch_a: assert property (take_w && mode_in == MODE_IMM |=> mem_rd_out && mem_addr_out == 16'($past(pc_in) + 16'h0001)) // RL4
    else $error("immediate byte not read after opcode");
  dir_page_a: assert property (ea_valid_out && mode_r == MODE_DIR |-> ea_out == b1_zx_w) // RL5
    else $error("direct address high byte not zero");
  ext_len_a: assert property (done_out && mode_r == MODE_EXT |-> len_out == 2'h3 && ea_out == b12_w) // RL6
    else $error("extended address or length wrong");
  ix0_addr_a: assert property (ea_valid_out && mode_r == MODE_IX0 |-> ea_out == chk_ix0_w && len_out == 2'h1) // RL7
    else $error("indexed no offset address wrong");
  ix1_range_a: assert property (ea_valid_out && mode_r == MODE_IX1 |-> ea_out <= `OA_IX8_MAX && ea_out == chk_ix1_w) // RL8
    else $error("indexed 8-bit address out of range");
  ix2_addr_a: assert property (ea_valid_out && mode_r == MODE_IX2 |-> ea_out == chk_ix2_w) // RL9 RL14
    else $error("indexed 16-bit address wrong");
  rel_taken_a: assert property (done_out && mode_r == MODE_REL && take_r |-> next_pc_out == chk_rel_w) // RL10 RL12
    else $error("taken branch target wrong");
  rel_skip_a: assert property (done_out && mode_r == MODE_REL && !take_r |-> next_pc_out == chk_seq_w) // RL11
    else $error("untaken branch did not fall through");
  mul_split_a: assert property (done_out && mul_r |-> regs_wr_out && {idx_out, acc_out} == mul_w) // RL2
    else $error("multiply product split wrong");
  seq_bound_a: assert property (take_w |-> ##[2:6] done_out && group_out == group_r) // RL13 RL1
    else $error("sequence did not finish in time");

  rel_take_c: cover property (done_out && mode_r == MODE_REL && take_r);
  ix2_c:      cover property (ea_valid_out && mode_r == MODE_IX2);
  mul_c:      cover property (regs_wr_out);
  imm_c:      cover property (literal_valid_out);
endmodule : cpu_operand_addressing

// ===== tb/mem_model.sv
// Purpose: program memory seen by the operand fetch, registered read
// Assumes: data is wanted in the cycle after the read strobe
// Notes:   content is addr low byte xor a5; idle data flips every cycle
`timescale 1ns/1ps
module mem_model (
  input  wire logic        core_clk_in, // system clock
  input  wire logic        rd_in,       // read strobe
  input  wire logic [15:0] addr_in,     // read address
  output logic      [7:0]  rdata_out    // read data
);
  initial rdata_out = 8'h00;
  // registered read; stale data is inverted each idle cycle, so it equals the last read byte every second idle cycle
  always @(posedge core_clk_in) begin
    if (rd_in) begin
      rdata_out <= addr_in[7:0] ^ 8'ha5;
    end else begin
      rdata_out <= ~rdata_out;
    end
  end
endmodule : mem_model

// ===== tb/testbench.sv
// Purpose: self-checking bench for operand fetch and address forming
// Assumes: one request at a time, each taken after the previous done
// Notes:   memory byte at a is a[7:0] xor a5, pc values chosen for it
`timescale 1ns/1ps
module testbench;
  import opaddr_pkg::*;
  logic        core_clk_in = 1'b0;
  logic        rst_in      = 1'b1;
  logic        start       = 1'b0;
  mode_t       mode        = MODE_INH;
  group_t      grp         = GRP_REGMEM;
  logic        mul         = 1'b0;
  logic        take        = 1'b0;
  logic [15:0] pc          = 16'h0000;
  logic [7:0]  acc         = 8'h00;
  logic [7:0]  idx         = 8'h00;
  logic [7:0]  rdata;
  logic        busy, mem_rd, done, ea_valid, lit_valid, regs_wr;
  logic [15:0] mem_addr, ea, next_pc;
  logic [7:0]  lit, acc_o, idx_o;
  logic [1:0]  len_o;
  group_t      grp_o;
  int          err_count = 0;
  int          checked   = 0;
  int          cyc       = 0;
  int          n;
  cpu_operand_addressing u_cpu_operand_addressing (.core_clk_in(core_clk_in), .rst_in(rst_in),
    .start_in(start), .mode_in(mode), .group_in(grp), .mul_in(mul), .take_in(take), .pc_in(pc),
    .acc_in(acc), .idx_in(idx), .mem_rdata_in(rdata), .busy_out(busy), .mem_rd_out(mem_rd),
    .mem_addr_out(mem_addr), .done_out(done), .ea_valid_out(ea_valid), .ea_out(ea),
    .literal_valid_out(lit_valid), .literal_out(lit), .next_pc_out(next_pc), .len_out(len_o),
    .group_out(grp_o), .regs_wr_out(regs_wr), .acc_out(acc_o), .idx_out(idx_o));
  mem_model u_mem_model (.core_clk_in(core_clk_in), .rd_in(mem_rd), .addr_in(mem_addr), .rdata_out(rdata));
  always #5 core_clk_in = ~core_clk_in;
  // watchdog on total run length
  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("errors %0d of %0d checks", err_count, checked);
    if (err_count == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // one request held for one edge, then count cycles to done
  task automatic op(input mode_t m, input group_t g, input logic mu, input logic tk,
                    input logic [15:0] p, input logic [7:0] a, input logic [7:0] x);
    @(posedge core_clk_in);
    start <= 1'b1; mode <= m; grp <= g; mul <= mu; take <= tk; pc <= p; acc <= a; idx <= x;
    @(posedge core_clk_in);
    start <= 1'b0;
    n = 0;
    do begin
      @(posedge core_clk_in);
      n++;
      #1;
    end while (done !== 1'b1 && n < 20);
  endtask : op
  // done shows after edge 2*len-1 past the take edge; then length, address, next pc, busy
  task automatic chk_res(input logic [1:0] l, input logic ev, input logic [15:0] e, input logic [15:0] np);
    chk(16'(n), 16'(2 * l - 1));
    chk({14'h0000, len_o}, {14'h0000, l});
    chk({15'h0000, ea_valid}, {15'h0000, ev});
    chk(ea, e);
    chk(next_pc, np);
    chk({15'h0000, busy}, 16'h0000);
  endtask : chk_res
  task automatic t_inherent();
    for (int g = 0; g < 5; g++) begin
      op(MODE_INH, group_t'(g), 1'b0, 1'b0, 16'h0100, 8'h12, 8'h34);
      chk_res(2'h1, 1'b0, 16'h0000, 16'h0101);
      chk({13'h0000, grp_o}, 16'(g));
      chk({15'h0000, regs_wr}, 16'h0000);
    end
  endtask : t_inherent
  task automatic t_mul();
    op(MODE_INH, GRP_REGMEM, 1'b1, 1'b0, 16'h0200, 8'h12, 8'h34);
    chk_res(2'h1, 1'b0, 16'h0000, 16'h0201);
    chk({15'h0000, regs_wr}, 16'h0001);
    chk({idx_o, acc_o}, 16'h03a8);
  endtask : t_mul
  task automatic t_imm();
    op(MODE_IMM, GRP_REGMEM, 1'b0, 1'b0, 16'h3000, 8'h00, 8'h00);
    chk_res(2'h2, 1'b0, 16'h0000, 16'h3002);
    chk({15'h0000, lit_valid}, 16'h0001);
    chk({8'h00, lit}, 16'h00a4);
  endtask : t_imm
  task automatic t_dir_ext();
    op(MODE_DIR, GRP_RMW, 1'b0, 1'b0, 16'h4510, 8'h00, 8'h00);
    chk_res(2'h2, 1'b1, 16'h00b4, 16'h4512);
    op(MODE_EXT, GRP_REGMEM, 1'b0, 1'b0, 16'hfffe, 8'h00, 8'h00);
    chk_res(2'h3, 1'b1, 16'h5aa5, 16'h0001);
  endtask : t_dir_ext
  task automatic t_indexed();
    op(MODE_IX0, GRP_REGMEM, 1'b0, 1'b0, 16'h8000, 8'h00, 8'h77);
    chk_res(2'h1, 1'b1, 16'h0077, 16'h8001);
    op(MODE_IX1, GRP_REGMEM, 1'b0, 1'b0, 16'h0059, 8'h00, 8'hff);
    chk_res(2'h2, 1'b1, 16'h01fe, 16'h005b);
    op(MODE_IX2, GRP_REGMEM, 1'b0, 1'b0, 16'h0059, 8'h00, 8'hff);
    chk_res(2'h3, 1'b1, 16'h00fd, 16'h005c);
  endtask : t_indexed
  task automatic t_rel();
    op(MODE_REL, GRP_JUMP, 1'b0, 1'b1, 16'h1024, 8'h00, 8'h00);
    chk_res(2'h2, 1'b0, 16'h0000, 16'h0fa6);
    op(MODE_REL, GRP_JUMP, 1'b0, 1'b0, 16'h1024, 8'h00, 8'h00);
    chk_res(2'h2, 1'b0, 16'h0000, 16'h1026);
    op(MODE_REL, GRP_JUMP, 1'b0, 1'b1, 16'h20d9, 8'h00, 8'h00);
    chk_res(2'h2, 1'b0, 16'h0000, 16'h215a);
    op(MODE_REL, GRP_JUMP, 1'b0, 1'b1, 16'hfffd, 8'h00, 8'h00);
    chk_res(2'h2, 1'b0, 16'h0000, 16'h005a);
  endtask : t_rel
  // main sequence: reset for two cycles, then each scenario once
  initial begin
    repeat (2) @(posedge core_clk_in);
    rst_in <= 1'b0;
    #1;
    chk({15'h0000, busy}, 16'h0000);
    chk({14'h0000, len_o}, 16'h0001);
    t_inherent();
    t_mul();
    t_imm();
    t_dir_ext();
    t_indexed();
    t_rel();
    end_of_test();
  end
endmodule : testbench
